// [design/enum_device_id_regs.sv]
`timescale 1ns/1ps
`include "enum_id_cfg.svh"
module enum_device_id_regs #(
  parameter logic [15:0] PART_NUMBER_CODE = `ENUM_ID_PART_NUMBER_RST,
  parameter logic [7:0] CATEGORY_CODE = `ENUM_ID_CATEGORY_RST
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Serial control port pins
  input wire enum_id_pkg::port_pins_in_t pins_in,
  output enum_id_pkg::port_pins_out_t pins_out,
  // Enumeration control and status
  input wire logic enum_exit_in,
  output logic enum_on_out,
  output logic clash_out
);
  import enum_id_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_PINS = 2;
  localparam int PIN_CLK = 0;
  localparam int PIN_DATA = 1;

  logic [SYNC_PINS-1:0] pin_raw;
  wire logic [SYNC_PINS-1:0] pin_safe;
  logic clk_line;
  logic data_line;
  logic clk_prev;
  logic clk_rise;
  logic clk_fall;

  assign pin_raw = {pins_in.data, pins_in.link_clk};

  // Two stages per pin; only the second stage is read by any logic
  for (genvar g = 0; g < SYNC_PINS; g++) begin : g_sync
    logic [1:0] stage;

    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
        stage <= 2'b00;
      end else begin
        stage <= {stage[0], pin_raw[g]};
      end
    end

    assign pin_safe[g] = stage[1];
  end

  assign clk_line = pin_safe[PIN_CLK];
  assign data_line = pin_safe[PIN_DATA];

  // Reset level matches the idle link clock, so no false edge follows reset
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_line;
    end
  end

  assign clk_rise = clk_line & ~clk_prev;
  assign clk_fall = ~clk_line & clk_prev;

  // ----------------------------------------------------------------
  // Identifier byte lookup
  // ----------------------------------------------------------------
  logic [7:0] part_number_high_byte;
  logic [7:0] part_number_low_byte;
  logic [7:0] device_category_byte;
  logic [47:0] enum_identifier;

  // Read-only registers: contents fixed by the build parameters
  assign part_number_high_byte = PART_NUMBER_CODE[15:8];
  assign part_number_low_byte = PART_NUMBER_CODE[7:0];
  assign device_category_byte = CATEGORY_CODE;

  // Only the part number and class fields belong to this block
  always_comb begin
    enum_identifier = '0;
    enum_identifier[`ENUM_ID_PART_HIGH_MSB:`ENUM_ID_PART_HIGH_LSB] =
      part_number_high_byte;
    enum_identifier[`ENUM_ID_PART_LOW_MSB:`ENUM_ID_PART_LOW_LSB] =
      part_number_low_byte;
    enum_identifier[`ENUM_ID_CATEGORY_MSB:`ENUM_ID_CATEGORY_LSB] =
      device_category_byte;
  end

  function automatic logic owned(input logic [7:0] ofs);
    owned = (ofs == `ENUM_ID_OFS_PART_HIGH) || (ofs == `ENUM_ID_OFS_PART_LOW) ||
      (ofs == `ENUM_ID_OFS_CATEGORY);
  endfunction : owned

  function automatic logic [7:0] id_byte(input logic [7:0] ofs, input logic on,
    input logic [47:0] ident);
    id_byte = `ENUM_ID_ZERO_BYTE;
    if (on) begin
      case (ofs)
        `ENUM_ID_OFS_PART_HIGH: id_byte =
          ident[`ENUM_ID_PART_HIGH_MSB:`ENUM_ID_PART_HIGH_LSB];
        `ENUM_ID_OFS_PART_LOW: id_byte =
          ident[`ENUM_ID_PART_LOW_MSB:`ENUM_ID_PART_LOW_LSB];
        `ENUM_ID_OFS_CATEGORY: id_byte =
          ident[`ENUM_ID_CATEGORY_MSB:`ENUM_ID_CATEGORY_LSB];
        default: id_byte = `ENUM_ID_ZERO_BYTE;
      endcase
    end
  endfunction : id_byte

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  port_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] addr_shift;
  logic [7:0] next_addr;
  logic [7:0] data_shift;
  logic driving;
  logic clash_now;
  logic addr_taken;
  logic enum_start;

  assign next_addr = {addr_shift[6:0], data_line};
  // Line read back at the falling edge differs from what was driven
  assign clash_now = (state == ST_DATA) && driving && clk_fall &&
    (data_line != pins_out.data);
  // The last address bit is taken at this link clock rise
  assign addr_taken = clk_rise && (state == ST_ADDR) &&
    (bit_cnt == `ENUM_ID_LAST_BIT);
  // Enumeration is entered only once the whole first offset has arrived
  assign enum_start = addr_taken && (next_addr == `ENUM_ID_OFS_FIRST);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      addr_shift <= 8'h00;
    end else if (clk_rise) begin
      case (state)
        ST_IDLE: begin
          if (data_line) begin
            state <= ST_ADDR;
            bit_cnt <= `ENUM_ID_ADDR_BITS;
          end
        end
        ST_ADDR: begin
          addr_shift <= next_addr;
          if (bit_cnt == `ENUM_ID_LAST_BIT) begin
            state <= owned(next_addr) ? ST_DATA : ST_SKIP;
            bit_cnt <= `ENUM_ID_DATA_BITS;
          end else begin
            bit_cnt <= bit_cnt - 4'h1;
          end
        end
        ST_DATA, ST_SKIP: begin
          if (bit_cnt == 4'h0) begin
            state <= ST_IDLE;
          end else begin
            bit_cnt <= bit_cnt - 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enumeration state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      enum_on_out <= 1'b0;
    end else if (clash_now) begin
      enum_on_out <= 1'b0;
    end else if (enum_start) begin
      // A start in the same cycle as an exit request wins
      enum_on_out <= 1'b1;
    end else if (enum_exit_in) begin
      enum_on_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      clash_out <= 1'b0;
    end else begin
      clash_out <= clash_now;
    end
  end

  // ----------------------------------------------------------------
  // Read data shifter and pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      data_shift <= 8'h00;
      driving <= 1'b0;
      pins_out <= '{data: 1'b0, data_oe_n: 1'b1};
    end else if (clash_now) begin
      data_shift <= 8'h00;
      pins_out.data <= 1'b0;
    end else if (clk_rise) begin
      // Enumeration state is sampled as the last address bit arrives
      if (addr_taken && owned(next_addr)) begin
        data_shift <= id_byte(next_addr, enum_on_out, enum_identifier);
      end else if (state == ST_DATA && bit_cnt != 4'h0) begin
        pins_out.data <= data_shift[7];
        pins_out.data_oe_n <= 1'b0;
        data_shift <= {data_shift[6:0], 1'b0};
        driving <= 1'b1;
      end else begin
        pins_out.data <= 1'b0;
        pins_out.data_oe_n <= 1'b1;
        driving <= 1'b0;
      end
    end
  end

endmodule : enum_device_id_regs

// [design/enum_id_cfg.svh]
`ifndef ENUM_ID_CFG_SVH
`define ENUM_ID_CFG_SVH

// Register offsets on the serial control port
`define ENUM_ID_OFS_FIRST 8'h50
`define ENUM_ID_OFS_PART_HIGH 8'h53
`define ENUM_ID_OFS_PART_LOW 8'h54
`define ENUM_ID_OFS_CATEGORY 8'h55

// Field positions inside the 48-bit enumeration identifier
`define ENUM_ID_PART_HIGH_MSB 23
`define ENUM_ID_PART_HIGH_LSB 16
`define ENUM_ID_PART_LOW_MSB 15
`define ENUM_ID_PART_LOW_LSB 8
`define ENUM_ID_CATEGORY_MSB 7
`define ENUM_ID_CATEGORY_LSB 0

// Reset values (part number value is arbitrary)
`define ENUM_ID_PART_NUMBER_RST 16'h5A3C
`define ENUM_ID_CATEGORY_RST 8'h00
`define ENUM_ID_ZERO_BYTE 8'h00

// Frame counts in link clock bits
`define ENUM_ID_ADDR_BITS 4'h8
`define ENUM_ID_DATA_BITS 4'h8
`define ENUM_ID_LAST_BIT 4'h1

`endif

// [design/enum_id_pkg.sv]
package enum_id_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_SKIP = 2'b11
  } port_state_t;

  // Pins of the serial control port as seen by the device
  typedef struct packed {
    logic link_clk;
    logic data;
  } port_pins_in_t;

  typedef struct packed {
    logic data;
    logic data_oe_n;
  } port_pins_out_t;

endpackage : enum_id_pkg

// [testbench/enum_id_chk.sv]
`timescale 1ns/1ps
module enum_id_chk (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire enum_id_pkg::port_pins_in_t pins_in,
  input wire enum_id_pkg::port_pins_out_t pins_out,
  input wire logic enum_exit_in,
  input wire logic enum_on_out,
  input wire logic clash_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  AST_CLASH_PULSE: assert property (clash_out |=> !clash_out)
    else $error("clash pulse too long");
  AST_CLASH_OFF: assert property (clash_out |=> !enum_on_out)
    else $error("enumeration kept after clash");
  AST_CLASH_DRV: assert property (clash_out |-> !$past(pins_out.data_oe_n))
    else $error("clash while not driving");
  AST_START_QUIET: assert property ($rose(enum_on_out) |-> pins_out.data_oe_n)
    else $error("start read was driven");
  AST_EXIT: assert property (enum_exit_in |=> !enum_on_out)
    else $error("exit ignored");
  AST_FALL_CAUSE: assert property ($fell(enum_on_out) |->
    $past(enum_exit_in) || clash_out || $past(clash_out))
    else $error("enumeration dropped without cause");
  AST_DRV_MIN: assert property ($fell(pins_out.data_oe_n) |=> !pins_out.data_oe_n [*8])
    else $error("data byte cut short");
  AST_DRV_LEN: assert property ($fell(pins_out.data_oe_n) |->
    ##[60:68] $rose(pins_out.data_oe_n))
    else $error("data byte length wrong");
endmodule : enum_id_chk
bind enum_device_id_regs enum_id_chk i_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
  .pins_in(pins_in), .pins_out(pins_out), .enum_exit_in(enum_exit_in),
  .enum_on_out(enum_on_out), .clash_out(clash_out));

// [testbench/enum_id_master.sv]
`timescale 1ns/1ps
module enum_id_master (
  input wire logic clk_in,
  input wire enum_id_pkg::port_pins_out_t dev_in,
  output enum_id_pkg::port_pins_in_t pins_out
);
  logic lclk = 1'b0;
  logic drv = 1'b0;
  logic cl = 1'b0;
  // Clash inverts the wire while the device drives
  assign pins_out.link_clk = lclk;
  assign pins_out.data = dev_in.data_oe_n ? drv : (dev_in.data ^ cl);
  // A quarter of the 200 ns link clock period
  task automatic qp();
    repeat (2) @(posedge clk_in);
  endtask : qp
  task automatic bt(input logic b);
    drv <= b;
    qp();
    qp();
    lclk <= 1'b1;
    qp();
    qp();
    lclk <= 1'b0;
  endtask : bt
  // Read value is the bit the device drives; ck picks a clash bit, 8 for none
  task automatic rd(input logic [7:0] a, input int ck, output logic [7:0] d, output logic s);
    s = 1'b0;
    bt(1'b1);
    for (int i = 7; i >= 0; i--) bt(a[i]);
    // Line rests low while the device answers
    drv <= 1'b0;
    qp();
    qp();
    for (int i = 7; i >= 0; i--) begin
      lclk <= 1'b1;
      qp();
      cl <= (7 - i == ck);
      qp();
      lclk <= 1'b0;
      qp();
      cl <= 1'b0;
      qp();
      d[i] = dev_in.data;
      s = s | !dev_in.data_oe_n;
    end
    lclk <= 1'b1;
    qp();
    qp();
    lclk <= 1'b0;
  endtask : rd
endmodule : enum_id_master

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`include "enum_id_cfg.svh"
module tb_top;
  import enum_id_pkg::*;
  localparam logic [15:0] PN = `ENUM_ID_PART_NUMBER_RST;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic enum_exit_in = 1'b0;
  logic enum_on_out, clash_out, clash_seen = 1'b0;
  port_pins_in_t pins_in;
  port_pins_out_t pins_out;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] d;
  logic s;
  always #12.5 clk_sys_in = ~clk_sys_in;
  enum_device_id_regs i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .pins_in(pins_in),
    .pins_out(pins_out), .enum_exit_in(enum_exit_in), .enum_on_out(enum_on_out),
    .clash_out(clash_out));
  enum_id_master i_master (.clk_in(clk_sys_in), .dev_in(pins_out), .pins_out(pins_in));
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (clash_out === 1'b1) clash_seen <= 1'b1;
    if (cycles == 8000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_master.rd(a, 8, d, s);
    chk("read byte", e, d);
    chk("read driven", 8'h01, {7'h00, s});
  endtask : rc
  task automatic t_off();
    rc(8'h53, 8'h00);
    rc(8'h54, 8'h00);
    rc(8'h55, 8'h00);
    i_master.rd(8'h56, 8, d, s);
    chk("unmapped driven", 8'h00, {7'h00, s});
  endtask : t_off
  task automatic t_on();
    i_master.rd(8'h50, 8, d, s);
    chk("enum on", 8'h01, {7'h00, enum_on_out});
    rc(8'h53, PN[15:8]);
    rc(8'h54, PN[7:0]);
    rc(8'h55, `ENUM_ID_CATEGORY_RST);
  endtask : t_on
  task automatic t_clash();
    i_master.rd(8'h53, 4, d, s);
    chk("partial byte", {PN[15:12], 4'h0}, d);
    chk("partial driven", 8'h01, {7'h00, s});
    chk("clash seen", 8'h01, {7'h00, clash_seen});
    chk("enum on", 8'h00, {7'h00, enum_on_out});
    rc(8'h54, 8'h00);
  endtask : t_clash
  task automatic t_exit();
    i_master.rd(8'h50, 8, d, s);
    chk("enum on", 8'h01, {7'h00, enum_on_out});
    @(posedge clk_sys_in) enum_exit_in <= 1'b1;
    @(posedge clk_sys_in) enum_exit_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk("enum on", 8'h00, {7'h00, enum_on_out});
    rc(8'h55, 8'h00);
  endtask : t_exit
  initial begin
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_off();
    t_on();
    t_clash();
    t_exit();
    finish_test();
  end
endmodule : tb_top
